// file: common/i2cmw_pkg.sv
// What this block does
// - First byte after START is the control byte; answer only code 1010.
// - Control-byte select bits must equal the three strap pin levels.
// - Control-byte bit 0 chooses direction: one is read, zero write.
// - A matching control byte is acknowledged by SDA low on pulse nine.
// - Two address bytes follow; only twelve bits used, upper bits zero.
// - Every address or data byte is acknowledged on its ninth pulse.
// - After the low address byte the pointer loads the full address.
// - STOP after data starts the write cycle; no STOP, no write.
// - No control-byte acknowledge while a write cycle runs.
// - Byte write at a page end wraps the pointer to page start.
// - Write protect still acknowledges, skips the cycle, updates pointer.
// - Page write takes up to a full page before the closing STOP.
// - More bytes than the buffer holds wrap and overwrite early ones.
// - Pointer never crosses the page; it wraps inside the addressed page.
// - First buffered byte goes to the start address, then successive.
// - Protected page write advances the pointer by byte count in page.
// - Write protect is sampled once, at the STOP ending the write.
// - After power-on release the device stays silent at most 75 us.
// - Page programming runs byte after byte, time scales with count.
// - SDA fall with SCL high is START, rise with SCL high is STOP.
// - Bytes are eight bits MSB first plus one acknowledge bit.
package i2cmw_pkg;

  // ==========================================================
  // Control byte and addressing
  localparam logic [3:0]  CTRL_CODE     = 4'ha;
  localparam int          CODE_MSB      = 7;
  localparam int          CODE_LSB      = 4;
  localparam int          SEL_MSB       = 3;
  localparam int          SEL_LSB       = 1;
  localparam int          RW_BIT        = 0;
  localparam int          ADDR_W        = 12;
  localparam int          ADDR_HI_BITS  = 4;
  localparam int          PAGE_W        = 5;
  localparam logic [5:0]  PAGE_BYTES    = 6'h20;

  // ==========================================================
  // Bit framing
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;

  // ==========================================================
  // Timing
  localparam int          MCLK_PERIOD_NS = 25;
  localparam int          POR_TIME_NS    = 75000;
  // Longest time, so division rounds down
  localparam logic [11:0] POR_CYCLES     = 12'(POR_TIME_NS / MCLK_PERIOD_NS);

  // ==========================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_DATA,
    ST_READ,
    ST_IGNORE
  } i2cmw_state_t;

endpackage

// file: hw/i2cmw_write_path.sv
`timescale 1ns/1ps
`default_nettype none
module i2cmw_write_path #(
  parameter int unsigned BYTE_PROG_CYCLES = 1200
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  input  wire logic        chip_select_strap_low,
  input  wire logic        chip_select_strap_mid,
  input  wire logic        chip_select_strap_high,
  input  wire logic        write_protect,
  output var  logic        read_req,
  output var  logic        write_busy,
  output var  logic [11:0] word_ptr,
  input  wire logic [11:0] mem_rd_addr,
  output var  logic [7:0]  mem_rd_data
);

  // ==========================================================
  // Elaboration checks
  // Below four the busy window is shorter than the stop check expects
  if (BYTE_PROG_CYCLES < 4 || BYTE_PROG_CYCLES > 65535) begin : g_bad_prog
    $error("BYTE_PROG_CYCLES must lie in 4..65535");
  end

  // ==========================================================
  // Functions
  function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] straps);
    ctrl_match = (b[i2cmw_pkg::CODE_MSB:i2cmw_pkg::CODE_LSB] == i2cmw_pkg::CTRL_CODE) &&
                 (b[i2cmw_pkg::SEL_MSB:i2cmw_pkg::SEL_LSB] == straps);
  endfunction

  // Offset advance that never leaves the page
  function automatic logic [11:0] page_inc(input logic [11:0] a, input logic [4:0] k);
    page_inc = {a[11:i2cmw_pkg::PAGE_W], 5'(a[4:0] + k)};
  endfunction

  // ==========================================================
  // Link domain: one flop captures SDA at each SCL rise
  logic scl_bit_reg;
  logic scl_tgl_reg;

  // Reset is a constant only; SCL may stand still, so no clocked reset here
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      scl_bit_reg <= 1'b1;
      scl_tgl_reg <= 1'b0;
    end else begin
      scl_bit_reg <= sda_i;
      scl_tgl_reg <= ~scl_tgl_reg;
    end
  end

  // ==========================================================
  // Synchronisers into mclk
  logic       scl_m1_reg, scl_m2_reg, scl_m3_reg;
  logic       sda_m1_reg, sda_m2_reg, sda_m3_reg;
  logic       tgl_m1_reg, tgl_m2_reg, tgl_m3_reg;
  logic [2:0] strap_m1_reg, strap_m2_reg;
  logic       wp_m1_reg, wp_m2_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_m1_reg   <= 1'b1;
      scl_m2_reg   <= 1'b1;
      scl_m3_reg   <= 1'b1;
      sda_m1_reg   <= 1'b1;
      sda_m2_reg   <= 1'b1;
      sda_m3_reg   <= 1'b1;
      tgl_m1_reg   <= 1'b0;
      tgl_m2_reg   <= 1'b0;
      tgl_m3_reg   <= 1'b0;
      strap_m1_reg <= 3'h0;
      strap_m2_reg <= 3'h0;
      wp_m1_reg    <= 1'b1;
      wp_m2_reg    <= 1'b1;
    end else begin
      scl_m1_reg   <= scl;
      scl_m2_reg   <= scl_m1_reg;
      scl_m3_reg   <= scl_m2_reg;
      sda_m1_reg   <= sda_i;
      sda_m2_reg   <= sda_m1_reg;
      sda_m3_reg   <= sda_m2_reg;
      tgl_m1_reg   <= scl_tgl_reg;
      tgl_m2_reg   <= tgl_m1_reg;
      tgl_m3_reg   <= tgl_m2_reg;
      strap_m1_reg <= {chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low};
      strap_m2_reg <= strap_m1_reg;
      wp_m1_reg    <= write_protect;
      wp_m2_reg    <= wp_m1_reg;
    end
  end

  // ==========================================================
  // Bus events
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_evt;

  assign start_det = scl_m2_reg & scl_m3_reg & sda_m3_reg & ~sda_m2_reg;
  assign stop_det  = scl_m2_reg & scl_m3_reg & ~sda_m3_reg & sda_m2_reg;
  assign scl_fall  = scl_m3_reg & ~scl_m2_reg;
  // Bit register is stable here: it only changes at the next SCL rise
  assign bit_evt   = tgl_m2_reg ^ tgl_m3_reg;

  // ==========================================================
  // Power-on hold
  logic [11:0] por_cnt_reg;
  logic        por_done;

  assign por_done = (por_cnt_reg == 12'h000);

  always_ff @(posedge mclk) begin
    if (rst) begin
      por_cnt_reg <= i2cmw_pkg::POR_CYCLES;
    end else if (!por_done) begin
      por_cnt_reg <= por_cnt_reg - 12'h001;
    end
  end

  // ==========================================================
  // Byte framing and protocol state
  i2cmw_pkg::i2cmw_state_t st_reg;
  logic [3:0]              bit_cnt_reg;
  logic [7:0]              shift_reg;
  logic [7:0]              shift_next;
  logic                    ack_ok_reg;
  logic                    ack_phase_reg;
  logic                    byte_done;
  logic                    busy_reg;

  assign shift_next = {shift_reg[6:0], scl_bit_reg};
  assign byte_done  = bit_evt && (st_reg != i2cmw_pkg::ST_IDLE) &&
                      (bit_cnt_reg == i2cmw_pkg::BIT_LAST);

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg        <= i2cmw_pkg::ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ack_ok_reg    <= 1'b0;
      ack_phase_reg <= 1'b0;
    end else if (!por_done) begin
      st_reg        <= i2cmw_pkg::ST_IDLE;
      ack_ok_reg    <= 1'b0;
      ack_phase_reg <= 1'b0;
    end else if (start_det) begin
      st_reg        <= i2cmw_pkg::ST_CTRL;
      bit_cnt_reg   <= 4'h0;
      ack_ok_reg    <= 1'b0;
      ack_phase_reg <= 1'b0;
    end else if (stop_det) begin
      st_reg        <= i2cmw_pkg::ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      ack_ok_reg    <= 1'b0;
      ack_phase_reg <= 1'b0;
    end else if (bit_evt && st_reg != i2cmw_pkg::ST_IDLE) begin
      if (bit_cnt_reg == i2cmw_pkg::BIT_ACK) begin
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        ack_ok_reg    <= 1'b0;
      end else begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == i2cmw_pkg::BIT_LAST) begin
          ack_phase_reg <= 1'b1;
          unique case (st_reg)
            i2cmw_pkg::ST_CTRL: begin
              // Busy silence is what lets the master poll for completion
              if (ctrl_match(shift_next, strap_m2_reg) && !busy_reg) begin
                ack_ok_reg <= 1'b1;
                st_reg     <= shift_next[i2cmw_pkg::RW_BIT] ? i2cmw_pkg::ST_READ
                                                             : i2cmw_pkg::ST_ADDR_HI;
              end else begin
                ack_ok_reg <= 1'b0;
                st_reg     <= i2cmw_pkg::ST_IGNORE;
              end
            end
            i2cmw_pkg::ST_ADDR_HI: begin
              ack_ok_reg <= 1'b1;
              st_reg     <= i2cmw_pkg::ST_ADDR_LO;
            end
            i2cmw_pkg::ST_ADDR_LO: begin
              ack_ok_reg <= 1'b1;
              st_reg     <= i2cmw_pkg::ST_DATA;
            end
            i2cmw_pkg::ST_DATA: begin
              ack_ok_reg <= 1'b1;
            end
            i2cmw_pkg::ST_READ,
            i2cmw_pkg::ST_IGNORE: begin
              ack_ok_reg <= 1'b0;
            end
            i2cmw_pkg::ST_IDLE: begin
              ack_ok_reg <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Acknowledge driver: changes only while SCL is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!por_done || start_det || stop_det) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      sda_oe <= ack_phase_reg & ack_ok_reg;
    end
  end

  // ==========================================================
  // Read hand-off: the read path itself sits outside this block
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_req <= 1'b0;
    end else begin
      read_req <= byte_done && (st_reg == i2cmw_pkg::ST_CTRL) && !busy_reg &&
                  ctrl_match(shift_next, strap_m2_reg) && shift_next[i2cmw_pkg::RW_BIT];
    end
  end

  // ==========================================================
  // Address pointer, start address and page buffer
  logic [3:0]  addr_hi_reg;
  logic [11:0] start_ptr_reg;
  logic [5:0]  data_cnt_reg;
  logic [7:0]  page_buf [0:31];

  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_hi_reg   <= 4'h0;
      start_ptr_reg <= 12'h000;
      word_ptr      <= 12'h000;
      data_cnt_reg  <= 6'h00;
    end else if (byte_done) begin
      if (st_reg == i2cmw_pkg::ST_ADDR_HI) begin
        // Upper high-byte bits are don't-care
        addr_hi_reg <= shift_next[i2cmw_pkg::ADDR_HI_BITS-1:0];
      end else if (st_reg == i2cmw_pkg::ST_ADDR_LO) begin
        word_ptr      <= {addr_hi_reg, shift_next};
        start_ptr_reg <= {addr_hi_reg, shift_next};
        data_cnt_reg  <= 6'h00;
      end else if (st_reg == i2cmw_pkg::ST_DATA) begin
        // Advanced even under write protect
        word_ptr <= page_inc(word_ptr, 5'h01);
        if (data_cnt_reg != i2cmw_pkg::PAGE_BYTES) begin
          data_cnt_reg <= data_cnt_reg + 6'h01;
        end
      end
    end
  end

  // Slot follows the pointer, so a 33rd byte lands on the 1st one's slot
  always_ff @(posedge mclk) begin
    if (byte_done && st_reg == i2cmw_pkg::ST_DATA) begin
      page_buf[word_ptr[4:0]] <= shift_next;
    end
  end

  // ==========================================================
  // Internally timed write cycle
  logic [15:0] prog_tmr_reg;
  logic [5:0]  prog_k_reg;
  logic        prog_byte;
  logic        go_write;
  logic [11:0] prog_addr;
  logic [7:0]  mem [0:4095];

  // Protect is looked at only in this one cycle
  assign go_write  = stop_det && (st_reg == i2cmw_pkg::ST_DATA) &&
                     (data_cnt_reg != 6'h00) && !wp_m2_reg;
  assign prog_byte = busy_reg && (prog_tmr_reg == 16'h0000);
  assign prog_addr = page_inc(start_ptr_reg, prog_k_reg[4:0]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      prog_tmr_reg <= 16'h0000;
      prog_k_reg   <= 6'h00;
    end else if (!busy_reg) begin
      if (go_write) begin
        busy_reg     <= 1'b1;
        prog_k_reg   <= 6'h00;
        prog_tmr_reg <= 16'(BYTE_PROG_CYCLES - 1);
      end
    end else if (prog_tmr_reg != 16'h0000) begin
      prog_tmr_reg <= prog_tmr_reg - 16'h0001;
    end else if (prog_k_reg == data_cnt_reg - 6'h01) begin
      busy_reg <= 1'b0;
    end else begin
      // One byte time per buffered word
      prog_k_reg   <= prog_k_reg + 6'h01;
      prog_tmr_reg <= 16'(BYTE_PROG_CYCLES - 1);
    end
  end

  always_ff @(posedge mclk) begin
    if (prog_byte) begin
      mem[prog_addr] <= page_buf[prog_addr[4:0]];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      write_busy  <= 1'b0;
      mem_rd_data <= 8'h00;
    end else begin
      write_busy  <= busy_reg;
      mem_rd_data <= mem[mem_rd_addr];
    end
  end

  // ==========================================================
  // Assertions
  logic [12:0] since_rst_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      since_rst_reg <= 13'h0000;
    end else if (since_rst_reg != 13'h1fff) begin
      since_rst_reg <= since_rst_reg + 13'h0001;
    end
  end

  a_por_bound: assert property (
    @(posedge mclk) disable iff (rst)
    (since_rst_reg >= 13'(i2cmw_pkg::POR_CYCLES)) |-> por_done)
    else $error("power-on hold too long");

  a_por_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    !por_done |-> (!sda_oe && st_reg == i2cmw_pkg::ST_IDLE))
    else $error("bus answered during power-on hold");

  a_start_ctrl: assert property (
    @(posedge mclk) disable iff (rst)
    (start_det && por_done) |=> (st_reg == i2cmw_pkg::ST_CTRL && bit_cnt_reg == 4'h0))
    else $error("start did not open a control byte");

  a_ctrl_ack: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && st_reg == i2cmw_pkg::ST_CTRL && !busy_reg && !start_det && !stop_det &&
     ctrl_match(shift_next, strap_m2_reg)) |=> ack_ok_reg)
    else $error("matching control byte not acknowledged");

  a_busy_nack: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && st_reg == i2cmw_pkg::ST_CTRL && busy_reg) |=>
      (!ack_ok_reg && st_reg == i2cmw_pkg::ST_IGNORE))
    else $error("control byte acknowledged while busy");

  a_ignore_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    (st_reg == i2cmw_pkg::ST_IGNORE) |-> !sda_oe)
    else $error("sda driven after non-matching control byte");

  a_ptr_load: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && st_reg == i2cmw_pkg::ST_ADDR_LO && por_done && !start_det && !stop_det)
      |=> (word_ptr == {addr_hi_reg, $past(shift_next)}))
    else $error("address pointer not loaded");

  a_ptr_page: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && st_reg == i2cmw_pkg::ST_DATA && por_done && !start_det && !stop_det)
      |=> (word_ptr[11:5] == $past(word_ptr[11:5]) &&
           word_ptr[4:0] == 5'($past(word_ptr[4:0]) + 5'h01)))
    else $error("pointer left its page");

  a_stop_write: assert property (
    @(posedge mclk) disable iff (rst)
    (go_write && !busy_reg) |=> busy_reg [*4])
    else $error("stop did not start a write cycle");

  a_wp_skip: assert property (
    @(posedge mclk) disable iff (rst)
    (stop_det && st_reg == i2cmw_pkg::ST_DATA && wp_m2_reg && !busy_reg) |=> !busy_reg)
    else $error("protected write started a cycle");

  a_busy_count: assert property (
    @(posedge mclk) disable iff (rst)
    $fell(busy_reg) |-> ($past(prog_byte) && $past(prog_k_reg) == data_cnt_reg - 6'h01))
    else $error("write cycle ended before last byte");

endmodule
`default_nettype wire

// file: verif/i2cmw_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus master model: drives SCL from its own clock, pulls SDA low
// SCL is divided down so high and low each exceed the slave's minimum
module i2cmw_master_model (
  input  wire logic lclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic half();
    repeat (5) @(posedge lclk);
  endtask

  // SDA falls while SCL high; also serves as repeated START
  task automatic start();
    sda_pull <= 1'b0;
    half();
    scl      <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl      <= 1'b0;
    half();
  endtask

  // SCL then stands still high until the next frame
  task automatic stop();
    sda_pull <= 1'b1;
    half();
    scl      <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask

  // Eight bits MSB first, then the ninth pulse samples the answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      @(posedge lclk);
      sda_pull <= ~b[i];
      half();
      scl      <= 1'b1;
      half();
      scl      <= 1'b0;
    end
    @(posedge lclk);
    sda_pull <= 1'b0;
    half();
    scl      <= 1'b1;
    half();
    ack = (sda === 1'b0);
    scl      <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// file: verif/tb_i2cmw_write_path.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_i2cmw_write_path;
  // ==========================================================
  // Clocks, wiring and instances
  localparam int BPC = 400;
  logic        mclk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst = 1'b1;
  logic        wp = 1'b0;
  logic [11:0] rd_addr = 12'h000;
  logic [2:0]  strap = 3'h5;
  logic        scl, sda_pull, sda, sda_o, sda_oe, read_req, write_busy;
  logic [11:0] word_ptr;
  logic [7:0]  rd_data;
  logic [7:0]  ctrl_w;
  int          n_errors = 0;
  int          n_checks = 0;
  int          rr_cnt = 0;

  always #12.5 mclk = ~mclk;
  // Link clock is free running but unrelated in phase to mclk
  initial begin
    #3.1;
    forever #24 lclk = ~lclk;
  end
  // Open drain with pull-up: low if either party pulls
  assign sda = ((sda_oe && !sda_o) || sda_pull) ? 1'b0 : 1'b1;
  assign ctrl_w = {i2cmw_pkg::CTRL_CODE, strap, 1'b0};
  always @(posedge mclk) if (read_req === 1'b1) rr_cnt++;

  i2cmw_master_model m (.lclk(lclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  i2cmw_write_path #(.BYTE_PROG_CYCLES(BPC)) DUT (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .chip_select_strap_low(strap[0]), .chip_select_strap_mid(strap[1]),
    .chip_select_strap_high(strap[2]), .write_protect(wp), .read_req(read_req),
    .write_busy(write_busy), .word_ptr(word_ptr), .mem_rd_addr(rd_addr),
    .mem_rd_data(rd_data));

  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    m.put_byte(b, ack);
    `CHK(ack, exp)
  endtask

  task automatic hdr(input logic [11:0] a);
    m.start();
    send(ctrl_w, 1'b1);
    send({4'h0, a[11:8]}, 1'b1);
    send(a[7:0], 1'b1);
    `CHK(word_ptr, a)
  endtask

  task automatic rd_mem(input logic [11:0] a, input logic [7:0] exp);
    @(negedge mclk) rd_addr = a;
    repeat (2) @(negedge mclk);
    `CHK(rd_data, exp)
  endtask

  // Busy length is counted; the bound keeps a stuck flag from hanging
  task automatic wait_idle(input int max, output int cyc);
    cyc = 0;
    while (write_busy === 1'b1) begin
      @(negedge mclk);
      cyc++;
      if (cyc > max) begin
        n_errors++;
        $display("mismatch at %0t: write cycle never ended", $time);
        tally_and_finish();
      end
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_por();
    repeat (100) @(negedge mclk);
    m.start();
    send(ctrl_w, 1'b0);
    m.stop();
    repeat (3005) @(negedge mclk);
    m.start();
    send(ctrl_w, 1'b1);
    m.stop();
  endtask

  task automatic t_byte_wrap();
    int c;
    hdr(12'h7ff);
    send(8'h3c, 1'b1);
    `CHK(word_ptr, 12'h7e0)
    m.stop();
    `CHK(write_busy, 1'b1)
    m.start();
    send(ctrl_w, 1'b0);
    m.stop();
    wait_idle(BPC + 50, c);
    rd_mem(12'h7ff, 8'h3c);
    m.start();
    send(ctrl_w, 1'b1);
    m.stop();
  endtask

  task automatic t_nomatch();
    logic [7:0] bad [4];
    bad = '{{4'hb, strap, 1'b0}, {4'ha, strap ^ 3'h1, 1'b0},
            {4'ha, strap ^ 3'h2, 1'b0}, {4'ha, strap ^ 3'h4, 1'b0}};
    foreach (bad[i]) begin
      m.start();
      send(bad[i], 1'b0);
      send(8'h00, 1'b0);
      m.stop();
    end
    // Selection must follow the strap pins, not a fixed pattern
    @(negedge mclk) strap = 3'h2;
    repeat (4) @(negedge mclk);
    m.start();
    send({i2cmw_pkg::CTRL_CODE, 3'h5, 1'b0}, 1'b0);
    m.start();
    send(ctrl_w, 1'b1);
    m.stop();
    @(negedge mclk) strap = 3'h5;
    repeat (4) @(negedge mclk);
  endtask

  // Repeated START instead of STOP must discard the data
  task automatic t_no_stop();
    hdr(12'h7ff);
    send(8'hc3, 1'b1);
    m.start();
    send(ctrl_w, 1'b1);
    m.stop();
    `CHK(write_busy, 1'b0)
    rd_mem(12'h7ff, 8'h3c);
  endtask

  // 34 bytes from offset 30: pointer and buffer both wrap in the page
  task automatic t_page();
    int c;
    hdr(12'h11e);
    for (int i = 0; i < 34; i++) send(8'h50 + 8'(i), 1'b1);
    `CHK(word_ptr, 12'h100)
    m.stop();
    wait_idle(32 * (BPC + 2) + 100, c);
    `CHK(c >= 32 * BPC - 20, 1'b1)
    for (int j = 0; j < 32; j++)
      rd_mem(12'h100 + 12'((30 + j) % 32), 8'h50 + 8'(j < 2 ? j + 32 : j));
  endtask

  task automatic t_protect();
    int c;
    @(negedge mclk) wp = 1'b1;
    hdr(12'h11f);
    for (int i = 0; i < 3; i++) send(8'hee, 1'b1);
    `CHK(word_ptr, 12'h102)
    m.stop();
    `CHK(write_busy, 1'b0)
    m.start();
    send(ctrl_w, 1'b1);
    m.stop();
    rd_mem(12'h11f, 8'h71);
    rd_mem(12'h100, 8'h52);
    @(negedge mclk) wp = 1'b0;
    hdr(12'h100);
    send(8'ha5, 1'b1);
    m.stop();
    @(negedge mclk) wp = 1'b1;
    wait_idle(BPC + 50, c);
    rd_mem(12'h100, 8'ha5);
    @(negedge mclk) wp = 1'b0;
  endtask

  task automatic t_read();
    `CHK(rr_cnt, 0)
    m.start();
    send({i2cmw_pkg::CTRL_CODE, strap, 1'b1}, 1'b1);
    m.stop();
    `CHK(rr_cnt, 1)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_por();
    t_byte_wrap();
    t_nomatch();
    t_no_stop();
    t_page();
    t_protect();
    t_read();
    tally_and_finish();
  end
endmodule
`default_nettype wire
